// ==== hw/lpu_map.svh ====
`ifndef LPU_MAP_SVH
`define LPU_MAP_SVH

// ==========================================================
// Register byte offsets on the APB window
`define LPU_ADDR_W 8
`define LPU_OFF_CTRL 8'h00
`define LPU_OFF_CFG 8'h04
`define LPU_OFF_BAUD 8'h08
`define LPU_OFF_STAT 8'h0C
`define LPU_OFF_INTC 8'h10
`define LPU_OFF_RDATA 8'h14
`define LPU_OFF_TDATA 8'h18

// ==========================================================
// Control register bit positions
`define LPU_CTRL_W 11
`define LPU_CTRL_UNIT_EN 0
`define LPU_CTRL_TX_EN 1
`define LPU_CTRL_RX_EN 2
`define LPU_CTRL_PCE 3
`define LPU_CTRL_ODD 4
`define LPU_CTRL_TX_COMPLETE_IRQ_EN 5
`define LPU_CTRL_RXIE 6
`define LPU_CTRL_PEIE 7
`define LPU_CTRL_ERROR_IRQ_EN 8
`define LPU_CTRL_DMA_TX 9
`define LPU_CTRL_DMA_RX 10

// ==========================================================
// Frame configuration register fields
`define LPU_CFG_W 6
`define LPU_CFG_WL_LSB 0
`define LPU_CFG_STOP_LSB 2
`define LPU_CFG_MSB_FIRST 4
`define LPU_CFG_TX_INV 5

// ==========================================================
// Status and clear register bit positions
`define LPU_ST_PE 0
`define LPU_ST_FE 1
`define LPU_ST_NE 2
`define LPU_ST_ORE 3
`define LPU_ST_RX_BUF_NONEMPTY 5
`define LPU_ST_TC 6
`define LPU_ST_TBE 7

// ==========================================================
// Reset values and timing
`define LPU_CTRL_RST 11'h000
`define LPU_CFG_RST 6'h00
`define LPU_BAUD_RST 20'h0_1000
`define LPU_BAUD_W 20
`define LPU_FRAC_STEP 21'h0_0100

`endif

// ==== hw/lpu_pkg.sv ====
package lpu_pkg;

  // ==========================================================
  // Transmitter states
  typedef enum logic [1:0] {
    TX_OFF = 2'b00,
    TX_PRE = 2'b01,
    TX_READY = 2'b10,
    TX_SHIFT = 2'b11
  } lpu_tx_state_e;

  // ==========================================================
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } lpu_rx_state_e;

  // Character word and bit counters
  typedef logic [8:0] lpu_word_t;
  typedef logic [3:0] lpu_count_t;

endpackage

// ==== hw/lpu_baud.sv ====
`timescale 1ns/1ps
`include "lpu_map.svh"

// ==========================================================
// Fractional bit-period tick generator
module lpu_baud
  import lpu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic half,
  input wire logic [`LPU_BAUD_W-1:0] divider,
  // Bit boundary pulse
  output logic tick
);

  logic [`LPU_BAUD_W:0] acc_ff; // Phase in 1/256 cycle units
  logic [`LPU_BAUD_W:0] nxt_acc;
  logic [`LPU_BAUD_W:0] sum;

  assign sum = acc_ff + `LPU_FRAC_STEP;

  // Adds 256 per cycle; divider/256 cycles per bit keeps the fraction
  always_comb
  begin
    tick = 1'b0;
    nxt_acc = acc_ff;
    if (restart)
    begin
      // Half start puts the first tick in the middle of a bit
      nxt_acc = half ? {2'b00, divider[`LPU_BAUD_W-1:1]} : '0;
    end
    else if (run)
    begin
      if (sum >= {1'b0, divider})
      begin
        tick = 1'b1;
        nxt_acc = sum - {1'b0, divider};
      end
      else
      begin
        nxt_acc = sum;
      end
    end
  end

  // Phase accumulator
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      acc_ff <= '0;
    else
      acc_ff <= nxt_acc;
  end

endmodule // lpu_baud

// ==== hw/lpu_core.sv ====
`timescale 1ns/1ps
`include "lpu_map.svh"

// Behaviour
// - Frame: start, data, parity, stop bits
// - Seven, eight, nine bits; LSB or MSB first
// - Stop code 00 one, 10 two
// - Idle frame all ones, normal length
// - Bit period is divider over 256 cycles
// - Line idles high; optional inversion
// - Enabling transmitter sends one idle frame
// - Buffer empty after reset and move, full after write
// - Buffer holds data until frame ends
// - Complete flag when buffer empty at end
// - Clear bit clears complete flag
// - High mid-start sample flags noise, drops
// - Data bits single mid-bit sample
// - Stored frame sets nonempty, raises interrupt
// - Any data read clears nonempty, unless a frame is stored in that cycle
// - Parity mismatch sets parity error
// - Framing error on low last stop
// - Frame on full buffer discarded, overrun
// - Parity and framing flags update with nonempty flag
// - DMA requests for both buffers
// - Error interrupts stay on with DMA
module lpu_core
  import lpu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`LPU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rx_in,
  output logic tx_out,
  // DMA
  output logic dma_tx_req,
  input wire logic dma_tx_valid,
  input wire logic [8:0] dma_tx_data,
  output logic dma_rx_req,
  input wire logic dma_rx_ack,
  output logic [8:0] rx_data,
  // Interrupt request
  output logic irq
);

  // ==========================================================
  // Decoders
  // Word length code to bit count
  function automatic lpu_count_t lpu_word_bits(input logic [1:0] code);
    lpu_word_bits = (code == 2'b01) ? 4'd9 : (code == 2'b10) ? 4'd7 : 4'd8;
  endfunction

  // Reverse the low n bits of a word
  function automatic lpu_word_t lpu_rev(input lpu_word_t w, input lpu_count_t n);
    lpu_rev = '0;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        lpu_rev[i] = w[int'(n) - 1 - i];
  endfunction

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Registers
  logic [`LPU_CTRL_W-1:0] ctrl_ff; // Enables and interrupt enables
  logic [`LPU_CFG_W-1:0] cfg_ff; // Frame format
  logic [`LPU_BAUD_W-1:0] baud_divider_ff; // Bit period times 256
  logic [31:0] prdata_ff; // Read data latched in setup
  logic [31:0] rd_mux;
  logic apb_wr;
  logic apb_rd;
  logic intc_wr;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign intc_wr = apb_wr && (paddr == `LPU_OFF_INTC);
  assign pready = 1'b1; // Zero wait states
  assign pslverr = 1'b0;
  assign prdata = prdata_ff;

  // Named fields
  logic unit_enable, tx_enable, rx_enable, parity_check_enable, parity_odd_select;
  logic tx_complete_irq_en, rx_nonempty_irq_en, parity_irq_en, error_irq_en;
  logic dma_tx_en, dma_rx_en, msb_first, tx_invert;
  logic [1:0] word_length_sel;
  logic [1:0] stop_bits_sel;
  assign unit_enable = ctrl_ff[`LPU_CTRL_UNIT_EN];
  assign tx_enable = ctrl_ff[`LPU_CTRL_TX_EN];
  assign rx_enable = ctrl_ff[`LPU_CTRL_RX_EN];
  assign parity_check_enable = ctrl_ff[`LPU_CTRL_PCE];
  assign parity_odd_select = ctrl_ff[`LPU_CTRL_ODD];
  assign tx_complete_irq_en = ctrl_ff[`LPU_CTRL_TX_COMPLETE_IRQ_EN];
  assign rx_nonempty_irq_en = ctrl_ff[`LPU_CTRL_RXIE];
  assign parity_irq_en = ctrl_ff[`LPU_CTRL_PEIE];
  assign error_irq_en = ctrl_ff[`LPU_CTRL_ERROR_IRQ_EN];
  assign dma_tx_en = ctrl_ff[`LPU_CTRL_DMA_TX];
  assign dma_rx_en = ctrl_ff[`LPU_CTRL_DMA_RX];
  assign word_length_sel = cfg_ff[`LPU_CFG_WL_LSB +: 2];
  assign stop_bits_sel = cfg_ff[`LPU_CFG_STOP_LSB +: 2];
  assign msb_first = cfg_ff[`LPU_CFG_MSB_FIRST];
  assign tx_invert = cfg_ff[`LPU_CFG_TX_INV];

  // Flags
  logic tx_buf_empty_ff, tx_complete_ff, rx_buf_nonempty_ff;
  logic noise_error_ff, parity_error_ff, framing_error_ff, overrun_error_ff;

  // Software-written registers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_ff <= `LPU_CTRL_RST;
      cfg_ff <= `LPU_CFG_RST;
      baud_divider_ff <= `LPU_BAUD_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == `LPU_OFF_CTRL)
        ctrl_ff <= pwdata[`LPU_CTRL_W-1:0];
      if (paddr == `LPU_OFF_CFG)
        cfg_ff <= pwdata[`LPU_CFG_W-1:0];
      if (paddr == `LPU_OFF_BAUD)
        baud_divider_ff <= pwdata[`LPU_BAUD_W-1:0];
    end
  end

  // Read multiplexer; unmapped and write-only offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `LPU_OFF_CTRL: rd_mux[`LPU_CTRL_W-1:0] = ctrl_ff;
      `LPU_OFF_CFG: rd_mux[`LPU_CFG_W-1:0] = cfg_ff;
      `LPU_OFF_BAUD: rd_mux[`LPU_BAUD_W-1:0] = baud_divider_ff;
      `LPU_OFF_STAT:
      begin
        rd_mux[`LPU_ST_PE] = parity_error_ff;
        rd_mux[`LPU_ST_FE] = framing_error_ff;
        rd_mux[`LPU_ST_NE] = noise_error_ff;
        rd_mux[`LPU_ST_ORE] = overrun_error_ff;
        rd_mux[`LPU_ST_RX_BUF_NONEMPTY] = rx_buf_nonempty_ff;
        rd_mux[`LPU_ST_TC] = tx_complete_ff;
        rd_mux[`LPU_ST_TBE] = tx_buf_empty_ff;
      end
      `LPU_OFF_RDATA: rd_mux[8:0] = rx_data;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Capture in setup so the access cycle sees settled data
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_ff <= rd_mux;
  end

  // ==========================================================
  // Transmit buffer
  logic tx_active, tdata_wr, tx_move;
  lpu_word_t tx_buf_ff;
  assign tx_active = unit_enable && tx_enable;
  assign tdata_wr = (apb_wr && (paddr == `LPU_OFF_TDATA)) || (dma_tx_valid && dma_tx_en);
  assign dma_tx_req = dma_tx_en && tx_active && tx_buf_empty_ff;

  // Holding register; any software or DMA write loads it, even when full
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tx_buf_ff <= '0;
    else if (tdata_wr)
      tx_buf_ff <= (dma_tx_valid && dma_tx_en) ? dma_tx_data : pwdata[8:0];
  end

  // Empty flag; the move into the shifter wins over a write
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tx_buf_empty_ff <= 1'b1;
    else if (tx_move)
      tx_buf_empty_ff <= 1'b1;
    else if (tdata_wr)
      tx_buf_empty_ff <= 1'b0;
  end

  tbe_reset_a: assert property ($fell(srst) |-> tx_buf_empty_ff)
    else $error("buffer empty flag not set after reset");

  // ==========================================================
  // Transmitter
  lpu_tx_state_e tx_st_ff;
  logic [11:0] tx_shift_ff; // Bit 0 is on the line
  lpu_count_t tx_cnt_ff; // Bits left in the frame
  logic tx_ff;
  logic tx_tick, tx_restart, tx_end;
  lpu_count_t tx_len, tx_n;
  lpu_word_t tx_word;
  logic [11:0] tx_frame;
  logic tx_par;

  assign tx_n = lpu_word_bits(word_length_sel);
  // Start plus data plus one or two stop bits
  assign tx_len = 4'd1 + tx_n + ((stop_bits_sel == 2'b10) ? 4'd2 : 4'd1);
  assign tx_end = (tx_st_ff == TX_PRE || tx_st_ff == TX_SHIFT) && tx_tick && (tx_cnt_ff == 4'd1);
  assign tx_move = tx_active && !tx_buf_empty_ff && ((tx_st_ff == TX_READY) || tx_end);
  assign tx_restart = tx_active && ((tx_st_ff == TX_OFF) || (tx_st_ff == TX_READY && !tx_buf_empty_ff));

  // Frame image, LSB goes first on the line
  always_comb
  begin
    tx_par = parity_odd_select;
    for (int i = 0; i < 9; i++)
      if (i < int'(tx_n) - 1)
        tx_par = tx_par ^ tx_buf_ff[i];
    tx_word = tx_buf_ff;
    if (parity_check_enable)
      tx_word[tx_n - 4'd1] = tx_par;
    if (msb_first)
      tx_word = lpu_rev(tx_word, tx_n);
    tx_frame = 12'hFFF; // Stop bits and padding are high
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++)
      if (i < int'(tx_n))
        tx_frame[i + 1] = tx_word[i];
  end

  lpu_baud u_tx_baud (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(tx_st_ff == TX_PRE || tx_st_ff == TX_SHIFT),
    .restart(tx_restart),
    .half(1'b0),
    .divider(baud_divider_ff),
    .tick(tx_tick)
  );

  // Idle frame first, then back-to-back frames from the buffer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tx_st_ff <= TX_OFF;
      tx_shift_ff <= 12'hFFF;
      tx_cnt_ff <= 4'd0;
    end
    else if (!tx_active)
      tx_st_ff <= TX_OFF;
    else if (tx_move)
    begin
      // Format is taken per frame so a mid-frame write cannot tear it
      tx_st_ff <= TX_SHIFT;
      tx_shift_ff <= tx_frame;
      tx_cnt_ff <= tx_len;
    end
    else
    begin
      unique case (tx_st_ff)
        TX_OFF:
        begin
          tx_st_ff <= TX_PRE;
          tx_shift_ff <= 12'hFFF;
          tx_cnt_ff <= tx_len;
        end
        TX_PRE, TX_SHIFT:
        begin
          if (tx_tick)
          begin
            tx_shift_ff <= {1'b1, tx_shift_ff[11:1]};
            tx_cnt_ff <= tx_cnt_ff - 4'd1;
            if (tx_cnt_ff == 4'd1)
              tx_st_ff <= TX_READY;
          end
        end
        TX_READY: tx_st_ff <= TX_READY;
      endcase
    end
  end

  // Registered pin; idle level (high unless tx_invert) whenever no frame is on the line
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tx_ff <= 1'b1;
    else if (tx_st_ff == TX_PRE || tx_st_ff == TX_SHIFT)
      tx_ff <= tx_shift_ff[0] ^ tx_invert;
    else
      tx_ff <= !tx_invert;
  end
  assign tx_out = tx_ff;

  // Complete flag; a new frame end wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tx_complete_ff <= 1'b0;
    else if (tx_end && tx_st_ff == TX_SHIFT && tx_buf_empty_ff)
      tx_complete_ff <= 1'b1;
    else if (intc_wr && pwdata[`LPU_ST_TC])
      tx_complete_ff <= 1'b0;
  end

  sequence tx_write_idle_s;
    tdata_wr && tx_buf_empty_ff && tx_active && tx_st_ff == TX_READY;
  endsequence
  tdata_move_a: assert property (tx_write_idle_s ##1 tx_active |-> !tx_buf_empty_ff ##1 tx_buf_empty_ff)
    else $error("idle write did not move straight to the shifter");
  tx_idle_high_a: assert property (tx_st_ff == TX_READY && $past(tx_st_ff) == TX_READY
                                   && $stable(tx_invert) |-> tx_ff == !tx_invert)
    else $error("line not idle high");
  tc_set_a: assert property (tx_end && tx_st_ff == TX_SHIFT && tx_buf_empty_ff |=> tx_complete_ff)
    else $error("complete flag missed at frame end");
  tx_pre_a: assert property (tx_active && tx_st_ff == TX_OFF && tx_buf_empty_ff
                             |=> tx_st_ff == TX_PRE && tx_cnt_ff == $past(tx_len))
    else $error("idle frame not started on enable");

  // ==========================================================
  // Receiver
  lpu_rx_state_e rx_st_ff;
  logic rx_s1_ff, rx_s2_ff, rx_prev_ff; // Two-stage synchroniser, then edge history
  lpu_word_t rx_word_ff; // Raw bits in line order
  lpu_word_t rx_data_ff;
  lpu_count_t rx_idx_ff, rx_n_ff;
  logic rx_stop2_ff;
  logic rx_active, rx_tick, rx_fall, frame_done, noise_evt, rdata_rd, rx_store, rx_overrun, rx_par_bad;
  lpu_word_t rx_word_final;

  assign rx_active = unit_enable && rx_enable;
  assign rx_fall = rx_prev_ff && !rx_s2_ff;
  assign noise_evt = (rx_st_ff == RX_START) && rx_tick && rx_s2_ff;
  assign frame_done = (rx_st_ff == RX_BITS) && rx_tick && (rx_idx_ff == rx_n_ff + {3'b000, rx_stop2_ff});
  assign rdata_rd = (apb_rd && (paddr == `LPU_OFF_RDATA)) || dma_rx_ack;
  // A read in the same cycle frees the buffer for the new frame
  assign rx_store = frame_done && (!rx_buf_nonempty_ff || rdata_rd);
  assign rx_overrun = frame_done && rx_buf_nonempty_ff && !rdata_rd;
  assign rx_word_final = msb_first ? lpu_rev(rx_word_ff, rx_n_ff) : rx_word_ff;
  assign dma_rx_req = dma_rx_en && rx_buf_nonempty_ff;
  assign rx_data = rx_data_ff;

  // Parity over data and parity bit together
  always_comb
  begin
    rx_par_bad = parity_odd_select;
    for (int i = 0; i < 9; i++)
      if (i < int'(rx_n_ff))
        rx_par_bad = rx_par_bad ^ rx_word_ff[i];
  end

  // Line synchroniser; only the second stage is looked at
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end
    else
    begin
      rx_s1_ff <= rx_in;
      rx_s2_ff <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
    end
  end

  lpu_baud u_rx_baud (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(rx_st_ff != RX_IDLE),
    .restart(rx_st_ff == RX_IDLE),
    .half(1'b1),
    .divider(baud_divider_ff),
    .tick(rx_tick)
  );

  // Start check, then one mid-bit sample per bit
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rx_st_ff <= RX_IDLE;
      rx_idx_ff <= 4'd0;
      rx_word_ff <= '0;
      rx_n_ff <= 4'd8;
      rx_stop2_ff <= 1'b0;
    end
    else if (!rx_active)
      rx_st_ff <= RX_IDLE;
    else
    begin
      unique case (rx_st_ff)
        RX_IDLE:
        begin
          if (rx_fall)
          begin
            rx_st_ff <= RX_START;
            rx_word_ff <= '0;
            rx_n_ff <= lpu_word_bits(word_length_sel);
            rx_stop2_ff <= (stop_bits_sel == 2'b10);
          end
        end
        RX_START:
        begin
          if (rx_tick)
          begin
            rx_st_ff <= rx_s2_ff ? RX_IDLE : RX_BITS;
            rx_idx_ff <= 4'd0;
          end
        end
        RX_BITS:
        begin
          if (rx_tick)
          begin
            if (rx_idx_ff < rx_n_ff)
              rx_word_ff[rx_idx_ff] <= rx_s2_ff;
            rx_idx_ff <= rx_idx_ff + 4'd1;
            if (frame_done)
              rx_st_ff <= RX_IDLE;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Receive data holding register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rx_data_ff <= '0;
    else if (rx_store)
      rx_data_ff <= rx_word_final;
  end

  // Nonempty flag; a stored frame wins over a read
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rx_buf_nonempty_ff <= 1'b0;
    else if (rx_store)
      rx_buf_nonempty_ff <= 1'b1;
    else if (rdata_rd)
      rx_buf_nonempty_ff <= 1'b0;
  end

  // Error flags; hardware set wins over the clear bits
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      parity_error_ff <= 1'b0;
      framing_error_ff <= 1'b0;
      noise_error_ff <= 1'b0;
      overrun_error_ff <= 1'b0;
    end
    else
    begin
      if (rx_store && parity_check_enable && rx_par_bad)
        parity_error_ff <= 1'b1;
      else if (intc_wr && pwdata[`LPU_ST_PE])
        parity_error_ff <= 1'b0;
      if (rx_store && !rx_s2_ff)
        framing_error_ff <= 1'b1;
      else if (intc_wr && pwdata[`LPU_ST_FE])
        framing_error_ff <= 1'b0;
      if (noise_evt)
        noise_error_ff <= 1'b1;
      else if (intc_wr && pwdata[`LPU_ST_NE])
        noise_error_ff <= 1'b0;
      if (rx_overrun)
        overrun_error_ff <= 1'b1;
      else if (intc_wr && pwdata[`LPU_ST_ORE])
        overrun_error_ff <= 1'b0;
    end
  end

  // Interrupt; error terms ignore the DMA enables
  assign irq = (tx_complete_ff && tx_complete_irq_en)
    || (rx_buf_nonempty_ff && rx_nonempty_irq_en)
    || (parity_error_ff && parity_irq_en)
    || (overrun_error_ff && (error_irq_en || rx_nonempty_irq_en))
    || ((noise_error_ff || framing_error_ff) && error_irq_en);

  sequence rx_frame_end_s;
    frame_done && !rx_buf_nonempty_ff;
  endsequence
  rx_store_a: assert property (rx_frame_end_s |=> rx_buf_nonempty_ff && rx_data_ff == $past(rx_word_final))
    else $error("received frame not stored");
  noise_drop_a: assert property (noise_evt && rx_active |=> noise_error_ff && rx_st_ff == RX_IDLE)
    else $error("noisy start bit not dropped");
  rx_buf_nonempty_clear_a: assert property (rdata_rd && !frame_done |=> !rx_buf_nonempty_ff)
    else $error("data read did not clear nonempty");
  overrun_keep_a: assert property (rx_overrun |=> overrun_error_ff && $stable(rx_data_ff))
    else $error("overrun frame overwrote data");
  // A read in the completing cycle keeps nonempty high, so look at the frame end instead of a rise
  parity_sync_a: assert property ($rose(parity_error_ff) |-> rx_buf_nonempty_ff && $past(frame_done))
    else $error("parity flag apart from nonempty");
  framing_sync_a: assert property ($rose(framing_error_ff) |-> rx_buf_nonempty_ff && $past(frame_done))
    else $error("framing flag apart from nonempty");

endmodule // lpu_core

// ==== verification/lpu_remote.sv ====
`timescale 1ns/1ps

// ==========================================================
// Far-end serial partner: 8 bits, LSB first, one stop bit
module lpu_remote #(parameter int BIT = 20) (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_q[$]; // Words decoded from the device
  initial line_out = 1'b1;
  // One frame; bad_stop drives the stop bit low
  task automatic send(input logic [7:0] d, input logic bad_stop);
    logic [9:0] f;
    f = {~bad_stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (BIT) @(posedge ref_clk);
    end
    line_out <= 1'b1;
  endtask
  // Low pulse far shorter than half a bit
  task automatic glitch();
    line_out <= 1'b0;
    repeat (3) @(posedge ref_clk);
    line_out <= 1'b1;
  endtask
  // Mid-bit sampling; a low stop bit drops the word
  always
  begin
    logic [7:0] w;
    @(negedge line_in);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge ref_clk);
      w[i] = line_in;
    end
    repeat (BIT) @(posedge ref_clk);
    if (line_in === 1'b1) got_q.push_back(w);
  end
endmodule // lpu_remote

// ==== verification/test_low_power_uart_core.sv ====
`timescale 1ns/1ps
`include "lpu_map.svh"

// ==========================================================
// Self-checking bench
module test_low_power_uart_core;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dma_rx_ack = 1'b0;
  logic dma_tx_valid = 1'b0;
  logic [8:0] dma_tx_data = 9'h000;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, rx_in, tx_out, dma_tx_req, dma_rx_req, irq;
  logic [8:0] rx_data;
  logic [31:0] seed = 32'h0000_002E; // Fixed seed
  logic [7:0] v;
  logic [7:0] exp_q[$]; // Words the peer must decode
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  lpu_core DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .tx_out(tx_out), .dma_tx_req(dma_tx_req), .dma_tx_valid(dma_tx_valid), .dma_tx_data(dma_tx_data),
    .dma_rx_req(dma_rx_req), .dma_rx_ack(dma_rx_ack), .rx_data(rx_data), .irq(irq));
  // Bit period 20 cycles matches divider 0x1400
  lpu_remote #(.BIT(20)) peer (.ref_clk(ref_clk), .line_in(tx_out), .line_out(rx_in));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bit mirror of a byte for MSB-first frames
  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      rev8[i] = d[7 - i];
  endfunction
  task automatic final_report();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; read data lands in r; idle edge after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Access holds until pready is seen high at an edge; only the hang guard ends a stall
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Poll a status bit, bounded
  task automatic wait_stat(input int b);
    int n;
    n = 0;
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    while (r[b] !== 1'b1 && n < 400)
    begin
      apb(1'b0, `LPU_OFF_STAT, 32'h0);
      n++;
    end
    chk("stat_bit", 32'h1, {31'h0, r[b]});
  endtask
  // One DMA word once the buffer asks; the request must drop while the word is held
  task automatic dma_push(input logic [8:0] d);
    while (dma_tx_req !== 1'b1)
      @(posedge ref_clk);
    dma_tx_valid <= 1'b1;
    dma_tx_data <= d;
    @(posedge ref_clk);
    dma_tx_valid <= 1'b0;
    @(posedge ref_clk);
    chk("dma_tx_req", 32'h0, {31'h0, dma_tx_req});
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    chk("stat_reset", 32'h0000_0080, r);
    apb(1'b1, `LPU_OFF_BAUD, 32'h0000_1400);
    apb(1'b1, `LPU_OFF_CTRL, 32'h0000_0127);
    repeat (260) @(posedge ref_clk);
    chk("idle_level", 32'h1, {31'h0, tx_out});
    chk("idle_words", 32'h0, peer.got_q.size());
    // Back-to-back writes exercise the holding buffer
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(rnd());
      exp_q.push_back(v);
      wait_stat(`LPU_ST_TBE);
      apb(1'b1, `LPU_OFF_TDATA, {24'h0, v});
    end
    wait_stat(`LPU_ST_TC);
    chk("tc_irq", 32'h1, {31'h0, irq});
    chk("tx_count", 32'h4, peer.got_q.size());
    for (int i = 0; i < 4; i++)
      chk("tx_word", {24'h0, exp_q[i]}, {24'h0, peer.got_q[i]});
    apb(1'b1, `LPU_OFF_INTC, 32'h0000_0040);
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    chk("tc_clear", 32'h0, {31'h0, r[`LPU_ST_TC] | irq});
    for (int i = 0; i < 3; i++)
    begin
      v = 8'(rnd());
      peer.send(v, 1'b0);
      wait_stat(`LPU_ST_RX_BUF_NONEMPTY);
      apb(1'b0, `LPU_OFF_RDATA, 32'h0);
      chk("rx_word", {24'h0, v}, r);
      apb(1'b0, `LPU_OFF_STAT, 32'h0);
      chk("rx_flags", 32'h0000_0080, r);
    end
    // Bad stop bit, then a second frame with no read between
    v = 8'(rnd());
    peer.send(v, 1'b1);
    repeat (40) @(posedge ref_clk);
    peer.send(8'h5A, 1'b0);
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    chk("fe_ore", 32'h0000_00AA, r);
    chk("err_irq", 32'h1, {31'h0, irq});
    apb(1'b0, `LPU_OFF_RDATA, 32'h0);
    chk("rx_kept", {24'h0, v}, r);
    apb(1'b1, `LPU_OFF_INTC, 32'h0000_000F);
    apb(1'b1, `LPU_OFF_CTRL, 32'h0000_051F);
    peer.glitch();
    repeat (40) @(posedge ref_clk);
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    chk("noise", 32'h0000_0084, r);
    chk("noise_irq", 32'h1, {31'h0, irq});
    apb(1'b1, `LPU_OFF_INTC, 32'h0000_000F);
    // Odd parity over the byte: any even byte is an error
    v = 8'(rnd());
    peer.send(v, 1'b0);
    chk("dma_req", 32'h1, {31'h0, dma_rx_req});
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    chk("parity", {31'h0, ~^v}, {31'h0, r[`LPU_ST_PE]});
    chk("dma_data", {24'h0, v}, {23'h0, rx_data});
    dma_rx_ack <= 1'b1;
    @(posedge ref_clk);
    dma_rx_ack <= 1'b0;
    @(posedge ref_clk);
    chk("dma_clear", 32'h0, {31'h0, dma_rx_req});
    // DMA feeds two MSB-first words framed with two stop bits
    apb(1'b1, `LPU_OFF_INTC, 32'h0000_000F);
    apb(1'b1, `LPU_OFF_CFG, 32'h0000_0018);
    apb(1'b1, `LPU_OFF_CTRL, 32'h0000_0227);
    for (int i = 0; i < 2; i++)
    begin
      v = 8'(rnd());
      exp_q.push_back(rev8(v));
      dma_push({1'b0, v});
    end
    wait_stat(`LPU_ST_TC);
    for (int i = 4; i < 6; i++)
      chk("tx_msb", {24'h0, exp_q[i]}, {24'h0, peer.got_q[i]});
    // Nine-bit MSB-first receive; the peer's stop bit lands as the ninth bit
    apb(1'b1, `LPU_OFF_CFG, 32'h0000_0019);
    v = 8'(rnd());
    peer.send(v, 1'b0);
    wait_stat(`LPU_ST_RX_BUF_NONEMPTY);
    apb(1'b0, `LPU_OFF_RDATA, 32'h0);
    chk("rx_9bit", {23'h0, rev8(v), 1'b1}, r);
    apb(1'b0, `LPU_OFF_STAT, 32'h0);
    chk("rx_stop2", 32'h0000_00C0, r);
    final_report();
  end
endmodule // test_low_power_uart_core
